// *** design/dcf_pkg.sv ***
// constants shared by the 9-bit dual-enable fifo with programmable flags
// assumes the top module and the testbench import this package
package dcf_pkg;
    localparam int         DCF_DW        = 9;
    localparam int         DCF_AW_DEF    = 8;
    localparam int         DCF_OFS_W     = 8;
    localparam int         DCF_OFS_N     = 4;
    localparam int         DCF_WR_PINS   = 12;
    localparam int         DCF_RD_PINS   = 4;
    // offset register slots in load order
    localparam logic [1:0] DCF_OFS_E_LO  = 2'h0;
    localparam logic [1:0] DCF_OFS_E_HI  = 2'h1;
    localparam logic [1:0] DCF_OFS_F_LO  = 2'h2;
    localparam logic [1:0] DCF_OFS_F_HI  = 2'h3;
    // reset values: seven words from empty and from full
    localparam logic [7:0] DCF_E_LO_RST  = 8'h07;
    localparam logic [7:0] DCF_E_HI_RST  = 8'h00;
    localparam logic [7:0] DCF_F_LO_RST  = 8'h07;
    localparam logic [7:0] DCF_F_HI_RST  = 8'h00;
    // cycles after reset release during which the mode pin is captured
    localparam logic [1:0] DCF_MODE_WIN  = 2'h3;
endpackage

// *** design/dcf_pin_sync.sv ***
// two-stage synchroniser for a group of pins
// assumes the pins are asynchronous to clock_i
`timescale 1ns/1ps
module dcf_pin_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         clock_i,
    input  wire logic         rstn_i,
    // pins and synchronised copy
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_sync;

    always_comb begin
        next_meta = pin_i;
        next_sync = meta;
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= next_meta;
            sync_o <= next_sync;
        end
    end
endmodule

// *** design/dcf_gray_sync.sv ***
// carries a gray-coded pointer across sides and returns it in binary
// assumes the source changes the gray value by at most one bit per step
`timescale 1ns/1ps
module dcf_gray_sync #(
    parameter int unsigned W = 9
) (
    // clock and reset
    input  wire logic         clock_i,
    input  wire logic         rstn_i,
    // gray pointer in, binary pointer out
    input  wire logic [W-1:0] gray_i,
    output logic      [W-1:0] bin_o
);
    logic [W-1:0] meta;
    logic [W-1:0] gsync;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_gsync;

    always_comb begin
        next_meta  = gray_i;
        next_gsync = meta;
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta  <= '0;
            gsync <= '0;
        end else begin
            meta  <= next_meta;
            gsync <= next_gsync;
        end
    end

    // gray to binary, read only from the second stage
    always_comb begin
        bin_o[W-1] = gsync[W-1];
        for (int i = W - 2; i >= 0; i--) begin
            bin_o[i] = bin_o[i+1] ^ gsync[i];
        end
    end
endmodule

// *** design/dcf_fifo_top.sv ***
// 9-bit fifo with write and read pins, programmable almost flags
// assumes write and read clock pins are sampled by clock_i, which must run
// at least four times faster than either of them
`timescale 1ns/1ps
module dcf_fifo_top #(
    parameter int unsigned AW = dcf_pkg::DCF_AW_DEF
) (
    // system clock and reset
    input  wire logic                       clock_i,
    input  wire logic                       rstn_i,
    // write pins
    input  wire logic                       wr_clock_i,
    input  wire logic [dcf_pkg::DCF_DW-1:0] din_i,
    input  wire logic                       wr_en_a_n_i,
    input  wire logic                       wr_en_b_load_i,
    // read pins
    input  wire logic                       rd_clock_i,
    input  wire logic                       rd_en_a_n_i,
    input  wire logic                       rd_en_b_n_i,
    input  wire logic                       out_en_n_i,
    // data out
    output logic      [dcf_pkg::DCF_DW-1:0] dout_o,
    output logic                            dout_en_o,
    // flags
    output logic                            empty_flag_n_o,
    output logic                            full_flag_n_o,
    output logic                            almost_empty_n_o,
    output logic                            almost_full_n_o
);
    import dcf_pkg::*;

    localparam logic [AW:0] DEPTH = {1'b1, {AW{1'b0}}};

    logic [DCF_WR_PINS-1:0] wsync;
    logic [DCF_RD_PINS-1:0] rsync;
    logic                   wclk_s;
    logic                   wen_a_s;
    logic                   load_s;
    logic                   rclk_s;
    logic                   ren_a_s;
    logic                   ren_b_s;
    logic                   oe_s;
    logic [DCF_DW-1:0]      din_s;
    logic                   wclk_d;
    logic                   rclk_d;
    logic                   wr_ev;
    logic                   rd_ev;
    logic [1:0]             win;
    logic [1:0]             next_win;
    logic                   prog;
    logic                   next_prog;
    logic                   run;
    logic [DCF_DW-1:0]      mem [2**AW];
    logic [AW:0]            wptr;
    logic [AW:0]            next_wptr;
    logic [AW:0]            rptr;
    logic [AW:0]            next_rptr;
    logic [AW:0]            wgray;
    logic [AW:0]            rgray;
    logic [AW:0]            wptr_rs;
    logic [AW:0]            rptr_ws;
    logic [AW:0]            wfill;
    logic [AW:0]            rfill;
    logic [AW:0]            rfill_now;
    logic [7:0]             ofs [DCF_OFS_N];
    logic [7:0]             next_ofs [DCF_OFS_N];
    logic [1:0]             widx;
    logic [1:0]             next_widx;
    logic [1:0]             ridx;
    logic [1:0]             next_ridx;
    logic [15:0]            ofs_e;
    logic [15:0]            ofs_f;
    logic                   wr_ok;
    logic                   wr_go;
    logic                   ofs_wr;
    logic                   rd_go;
    logic                   ofs_rd;
    logic                   next_full_n;
    logic                   next_af_n;
    logic                   next_empty_n;
    logic                   next_ae_n;
    logic [DCF_DW-1:0]      next_dout;

    // pin capture
    dcf_pin_sync #(.W(DCF_WR_PINS)) u_wsync (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .pin_i   ({wr_clock_i, wr_en_a_n_i, wr_en_b_load_i, din_i}),
        .sync_o  (wsync)
    );
    dcf_pin_sync #(.W(DCF_RD_PINS)) u_rsync (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .pin_i   ({rd_clock_i, rd_en_a_n_i, rd_en_b_n_i, out_en_n_i}),
        .sync_o  (rsync)
    );
    assign {wclk_s, wen_a_s, load_s, din_s} = wsync;
    assign {rclk_s, ren_a_s, ren_b_s, oe_s} = rsync;
    assign wr_ev = wclk_s & ~wclk_d;
    assign rd_ev = rclk_s & ~rclk_d;

    // pointers cross in gray code
    assign wgray = wptr ^ (wptr >> 1);
    assign rgray = rptr ^ (rptr >> 1);
    dcf_gray_sync #(.W(AW + 1)) u_w2r (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .gray_i  (wgray),
        .bin_o   (wptr_rs)
    );
    dcf_gray_sync #(.W(AW + 1)) u_r2w (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .gray_i  (rgray),
        .bin_o   (rptr_ws)
    );

    // mode capture: load mode when the pin is low around reset
    always_comb begin
        run       = (win == DCF_MODE_WIN);
        next_win  = run ? win : win + 2'h1;
        next_prog = run ? prog : ~load_s;
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            win    <= 2'h0;
            prog   <= 1'b0;
            wclk_d <= 1'b0;
            rclk_d <= 1'b0;
        end else begin
            win    <= next_win;
            prog   <= next_prog;
            wclk_d <= wclk_s;
            rclk_d <= rclk_s;
        end
    end

    // write side
    assign ofs_e = {ofs[DCF_OFS_E_HI], ofs[DCF_OFS_E_LO]};
    assign ofs_f = {ofs[DCF_OFS_F_HI], ofs[DCF_OFS_F_LO]};

    always_comb begin
        // enable a low, second term load pin high in both modes, never while full
        wr_ok  = !wen_a_s && load_s && full_flag_n_o;
        wr_go  = wr_ev && run && wr_ok;
        ofs_wr = wr_ev && run && prog && !load_s && !wen_a_s;
        next_wptr = wr_go ? wptr + 1'b1 : wptr;
        next_widx = ofs_wr ? widx + 2'h1 : widx;
        for (int i = 0; i < DCF_OFS_N; i++) begin
            next_ofs[i] = ofs[i];
        end
        if (ofs_wr) begin
            next_ofs[widx] = din_s[7:0];
        end
        // free space judged against the late read pointer, so full errs safe
        wfill       = next_wptr - rptr_ws;
        next_full_n = full_flag_n_o;
        next_af_n   = almost_full_n_o;
        if (wr_ev) begin
            next_full_n = (wfill != DEPTH);
            // low once fill plus m reaches the depth
            next_af_n = (17'(wfill) + 17'(ofs_f)) < 17'(DEPTH);
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wptr            <= '0;
            widx            <= DCF_OFS_E_LO;
            ofs[0]          <= DCF_E_LO_RST;
            ofs[1]          <= DCF_E_HI_RST;
            ofs[2]          <= DCF_F_LO_RST;
            ofs[3]          <= DCF_F_HI_RST;
            full_flag_n_o   <= 1'b1;
            almost_full_n_o <= 1'b1;
        end else begin
            wptr            <= next_wptr;
            widx            <= next_widx;
            ofs             <= next_ofs;
            full_flag_n_o   <= next_full_n;
            almost_full_n_o <= next_af_n;
        end
    end

    // memory has no reset; a word is read only after it is written
    always_ff @(posedge clock_i) begin
        if (wr_go) begin
            mem[wptr[AW-1:0]] <= din_s;
        end
    end

    // read side
    always_comb begin
        rfill_now = wptr_rs - rptr;
        ofs_rd = rd_ev && run && prog && !load_s && !ren_a_s && !ren_b_s;
        rd_go  = rd_ev && run && !ren_a_s && !ren_b_s && !ofs_rd
                 && (rfill_now != '0);
        next_rptr = rd_go ? rptr + 1'b1 : rptr;
        next_ridx = ofs_rd ? ridx + 2'h1 : ridx;
        // an empty fifo keeps the last word on the outputs
        next_dout = dout_o;
        if (rd_go) begin
            next_dout = mem[rptr[AW-1:0]];
        end else if (ofs_rd) begin
            next_dout = {1'b0, ofs[ridx]};
        end
        rfill        = wptr_rs - next_rptr;
        next_empty_n = empty_flag_n_o;
        next_ae_n    = almost_empty_n_o;
        if (rd_ev) begin
            next_empty_n = (rfill != '0);
            next_ae_n    = 16'(rfill) > ofs_e;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rptr             <= '0;
            ridx             <= DCF_OFS_E_LO;
            dout_o           <= '0;
            dout_en_o        <= 1'b0;
            empty_flag_n_o   <= 1'b0;
            almost_empty_n_o <= 1'b0;
        end else begin
            rptr             <= next_rptr;
            ridx             <= next_ridx;
            dout_o           <= next_dout;
            // held off until the mode capture window has ended
            dout_en_o        <= run & ~oe_s;
            empty_flag_n_o   <= next_empty_n;
            almost_empty_n_o <= next_ae_n;
        end
    end

    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    dual_write_a: assert property (wr_ev && run && !prog && !wen_a_s
        && load_s && full_flag_n_o |=> wptr == $past(wptr) + 1'b1)
        else $error("dual-enable write not taken");
    prog_write_a: assert property (wr_ev && run && prog && !wen_a_s
        && load_s && full_flag_n_o |=> wptr == $past(wptr) + 1'b1)
        else $error("flag-mode write not taken");
    full_hold_a: assert property (!full_flag_n_o |=> $stable(wptr)
        && ($past(wr_ev) || !full_flag_n_o))
        else $error("write pointer moved while full");
    mode_pick_a: assert property (!run ##1 run
        |-> prog == $past(~load_s))
        else $error("mode not taken from pin");
    ofs_seq_a: assert property (ofs_wr |=> widx == $past(widx) + 2'h1
        && ofs[$past(widx)] == $past(din_s[7:0]))
        else $error("offset write out of order");
    read_data_a: assert property (rd_go ##1 !rd_ev
        |=> dout_o == $past(dout_o))
        else $error("read data not held");
    empty_only_rd_a: assert property (!rd_ev
        |=> $stable(empty_flag_n_o))
        else $error("empty flag moved off a read edge");
    full_only_wr_a: assert property (!wr_ev
        |=> $stable(full_flag_n_o))
        else $error("full flag moved off a write edge");
    ae_level_a: assert property (rd_ev |=> almost_empty_n_o
        == (16'($past(rfill)) > $past(ofs_e)))
        else $error("almost-empty level wrong");
    af_level_a: assert property (wr_ev |=> almost_full_n_o
        == ((17'($past(wfill)) + 17'($past(ofs_f))) < 17'(DEPTH)))
        else $error("almost-full level wrong");

    // level, pointer, data and output-enable checks
    empty_level_a: assert property (rd_ev |=> empty_flag_n_o
        == ($past(rfill) != '0))
        else $error("empty flag level wrong");
    full_level_a: assert property (wr_ev |=> full_flag_n_o
        == ($past(wfill) != DEPTH))
        else $error("full flag level wrong");
    no_underrun_a: assert property (rfill_now == '0 |=> $stable(rptr))
        else $error("read taken from an empty fifo");
    ofs_no_fifo_a: assert property (ofs_wr |=> $stable(wptr))
        else $error("offset write reached the fifo");
    ofs_rd_step_a: assert property (ofs_rd
        |=> ridx == $past(ridx) + 2'h1 && $stable(rptr))
        else $error("offset read out of order");
    gray_step_a: assert property (1'b1 |->
        $countones(wgray ^ $past(wgray)) <= 1
        && $countones(rgray ^ $past(rgray)) <= 1)
        else $error("pointer moved by more than one gray step");
    idle_dout_a: assert property (!rd_ev |=> $stable(dout_o))
        else $error("read data moved off a read edge");
    window_idle_a: assert property (!run
        |=> $stable(wptr) && $stable(rptr) && $stable(widx))
        else $error("pin event taken inside the mode window");
    oe_follow_a: assert property (run && !oe_s |=> dout_en_o)
        else $error("outputs not driven with enable low");
    oe_drive_a: assert property (oe_s |=> !dout_en_o)
        else $error("outputs driven with enable high");

    fill_full_c: cover property (wr_ev ##1 !full_flag_n_o);
    drain_c: cover property (rd_go ##1 !empty_flag_n_o);
    ofs_wrap_c: cover property (ofs_wr && widx == DCF_OFS_F_HI);
    ofs_read_c: cover property (ofs_rd);
    refuse_c: cover property (wr_ev && !full_flag_n_o && !wen_a_s);
endmodule

// *** tb/dcf_pin_model.sv ***
// pin-level writer and reader that face the fifo pins
// assumes one cycle at a time, paced by the fifo system clock
`timescale 1ns/1ps
module dcf_pin_model (
    // system clock
    input  wire logic       clock_i,
    // write pins
    output logic            wr_clock_o,
    output logic [8:0]      din_o,
    output logic            wr_en_a_n_o,
    output logic            wr_en_b_load_o,
    // read pins
    output logic            rd_clock_o,
    output logic            rd_en_a_n_o,
    output logic            rd_en_b_n_o,
    output logic            out_en_n_o
);
    initial begin
        wr_clock_o = 1'b0;
        din_o = 9'h000;
        wr_en_a_n_o = 1'b1;
        wr_en_b_load_o = 1'b1;
        rd_clock_o = 1'b0;
        rd_en_a_n_o = 1'b1;
        rd_en_b_n_o = 1'b1;
        out_en_n_o = 1'b1;
    end
    // mode pin level held across reset and after release
    task automatic set_mode(input logic b);
        wr_en_b_load_o <= b;
    endtask
    task automatic set_oe(input logic v);
        @(posedge clock_i);
        out_en_n_o <= v;
    endtask
    // pin clocks stand still outside a cycle; pins set 3 edges before the clock rises, held 5 after
    task automatic wr_cycle(input logic [8:0] d, input logic a_n,
                            input logic b);
        @(posedge clock_i);
        din_o <= d;
        wr_en_a_n_o <= a_n;
        wr_en_b_load_o <= b;
        repeat (3) @(posedge clock_i);
        wr_clock_o <= 1'b1;
        repeat (5) @(posedge clock_i);
        wr_clock_o <= 1'b0;
        // released data does not keep its last value
        din_o <= ~d;
        @(posedge clock_i);
    endtask
    task automatic rd_cycle(input logic a_n, input logic b_n);
        @(posedge clock_i);
        rd_en_a_n_o <= a_n;
        rd_en_b_n_o <= b_n;
        repeat (3) @(posedge clock_i);
        rd_clock_o <= 1'b1;
        repeat (5) @(posedge clock_i);
        rd_clock_o <= 1'b0;
        @(posedge clock_i);
    endtask
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the fifo, compared with a queue model
// assumes sequential pin cycles; flags checked on their own side only
`timescale 1ns/1ps
module testbench;
    import dcf_pkg::*;
    localparam int AW = 6;
    localparam int DEPTH = 1 << AW;
    logic       clock_i = 1'b0;
    logic       rstn_i = 1'b0;
    wire        wr_clock, wr_en_a_n, wr_en_b_load;
    wire        rd_clock, rd_en_a_n, rd_en_b_n, out_en_n;
    wire  [8:0] din;
    logic [8:0] dout_o;
    logic       dout_en_o, empty_flag_n_o, full_flag_n_o;
    logic       almost_empty_n_o, almost_full_n_o;
    int         mismatches = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    int         q[$];
    int         ofs[4];
    int         wi, ri, ldm;
    logic [8:0] last;

    dcf_pin_model pm_i (.clock_i(clock_i), .wr_clock_o(wr_clock),
        .din_o(din), .wr_en_a_n_o(wr_en_a_n),
        .wr_en_b_load_o(wr_en_b_load), .rd_clock_o(rd_clock),
        .rd_en_a_n_o(rd_en_a_n), .rd_en_b_n_o(rd_en_b_n),
        .out_en_n_o(out_en_n));
    dcf_fifo_top #(.AW(AW)) dcf_fifo_top_i (.clock_i(clock_i),
        .rstn_i(rstn_i), .wr_clock_i(wr_clock), .din_i(din),
        .wr_en_a_n_i(wr_en_a_n), .wr_en_b_load_i(wr_en_b_load),
        .rd_clock_i(rd_clock), .rd_en_a_n_i(rd_en_a_n),
        .rd_en_b_n_i(rd_en_b_n), .out_en_n_i(out_en_n),
        .dout_o(dout_o), .dout_en_o(dout_en_o),
        .empty_flag_n_o(empty_flag_n_o), .full_flag_n_o(full_flag_n_o),
        .almost_empty_n_o(almost_empty_n_o),
        .almost_full_n_o(almost_full_n_o));

    initial forever #2 clock_i = ~clock_i;

    task automatic final_report();
        if (mismatches == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            final_report();
        end
    end
    task automatic chk_word(input string nm, input logic [8:0] e,
                            input logic [8:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_flag(input string nm, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic do_reset(input logic b);
        @(posedge clock_i);
        rstn_i <= 1'b0;
        pm_i.set_mode(b);
        repeat (5) @(posedge clock_i);
        chk_flag("empty_rst", 1'b0, empty_flag_n_o);
        chk_flag("full_rst", 1'b1, full_flag_n_o);
        chk_flag("ae_rst", 1'b0, almost_empty_n_o);
        chk_flag("af_rst", 1'b1, almost_full_n_o);
        chk_word("dout_rst", 9'h000, dout_o);
        rstn_i <= 1'b1;
        repeat (8) @(posedge clock_i);
        q.delete();
        ofs = '{7, 0, 7, 0};
        wi = 0;
        ri = 0;
        ldm = !b;
        last = 9'h000;
    endtask
    task automatic do_write(input logic [8:0] d, input logic a_n,
                            input logic b);
        int m;
        // the flag at an offset write still sees the full offset before it
        m = ofs[2] + 256 * ofs[3];
        pm_i.wr_cycle(d, a_n, b);
        if (!a_n && b && q.size() < DEPTH)
            q.push_back(int'(d));
        else if (!a_n && !b && ldm) begin
            ofs[wi] = int'(d[7:0]);
            wi = (wi + 1) % 4;
        end
        chk_flag("full", q.size() != DEPTH, full_flag_n_o);
        chk_flag("almost_full", q.size() + m < DEPTH,
                 almost_full_n_o);
    endtask
    task automatic do_read(input logic a_n, input logic b_n);
        pm_i.rd_cycle(a_n, b_n);
        if (!a_n && !b_n) begin
            if (ldm && !wr_en_b_load) begin
                last = {1'b0, 8'(ofs[ri])};
                ri = (ri + 1) % 4;
            end else if (q.size() > 0)
                last = 9'(q.pop_front());
        end
        chk_word("dout", last, dout_o);
        chk_flag("empty", q.size() != 0, empty_flag_n_o);
        chk_flag("almost_empty", q.size() > ofs[0] + 256 * ofs[1],
                 almost_empty_n_o);
    endtask
    // random enables, fill to refusal, drain past empty
    task automatic fill_drain();
        repeat (8) do_write(9'($urandom), ($urandom % 4) == 0,
                            ($urandom % 4) != 0);
        while (q.size() < DEPTH)
            do_write(9'($urandom), 1'b0, 1'b1);
        repeat (3) do_write(9'($urandom), 1'b0, 1'b1);
        repeat (8) do_read(($urandom % 4) == 0, ($urandom % 4) == 0);
        while (q.size() > 0)
            do_read(1'b0, 1'b0);
        repeat (2) do_read(1'b0, 1'b0);
    endtask

    initial begin
        void'($urandom(32'h21f612bb));
        do_reset(1'b1);
        fill_drain();
        pm_i.set_oe(1'b0);
        repeat (5) @(posedge clock_i);
        chk_flag("dout_en", 1'b1, dout_en_o);
        pm_i.set_oe(1'b1);
        repeat (5) @(posedge clock_i);
        chk_flag("dout_en", 1'b0, dout_en_o);
        do_reset(1'b0);
        fill_drain();
        do_write({1'b0, 8'(1 + $urandom % 12)}, 1'b0, 1'b0);
        do_write(9'h000, 1'b0, 1'b0);
        do_write({1'b0, 8'(1 + $urandom % 12)}, 1'b0, 1'b0);
        do_write(9'h000, 1'b0, 1'b0);
        do_write({1'b0, 8'(1 + $urandom % 12)}, 1'b0, 1'b0);
        repeat (5) do_read(1'b0, 1'b0);
        fill_drain();
        final_report();
    end
endmodule
